//--- hdl/scs_pkg.sv
package scs_pkg;

  // Widths
  localparam int DIV_W  = 8;
  localparam int CNT_W  = DIV_W + 1;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;

  // Core clock figures
  localparam int CORE_CLK_PERIOD_NS = 25;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RATE   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TXDATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RXDATA = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

  // Clock stop modes handled here
  localparam logic [1:0] MODE_STOP_NODLY = 2'h2;
  localparam logic [1:0] MODE_STOP_DLY   = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register layout, bit 0 is clock_stop_mode[0]
  typedef struct packed {
    logic       rate_gen_source_sel;
    logic       rx_frame_direction;
    logic       rx_clock_direction;
    logic       tx_frame_direction;
    logic       tx_clock_direction;
    logic       rx_frame_polarity;
    logic       tx_frame_polarity;
    logic       tx_clock_polarity;
    logic [1:0] clock_stop_mode;
  } scs_ctrl_s;

  // Status register layout
  typedef struct packed {
    logic cfg_err;
    logic tx_pending;
    logic rx_full;
    logic busy;
  } scs_status_s;

  localparam scs_ctrl_s         CTRL_RST = scs_ctrl_s'(10'h000);
  localparam logic [DIV_W-1:0]  RATE_RST = 8'h01;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // Master sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_LEAD  = 4'h2,
    ST_SHIFT = 4'h4,
    ST_TRAIL = 4'h8
  } scs_state_e;

  // Divider zero would need a half-cycle phase, so it runs as one
  function automatic logic [CNT_W-1:0] scs_div_eff(input logic [DIV_W-1:0] div);
    return (div == '0) ? CNT_W'(1) : {1'b0, div};
  endfunction : scs_div_eff

  // Bit clock high phase in core cycles
  function automatic logic [CNT_W-1:0] scs_high_len(input logic [DIV_W-1:0] div);
    logic [CNT_W-1:0] d;
    d = scs_div_eff(div);
    return d[0] ? ((d + 1'b1) >> 1) : ((d >> 1) + 1'b1);
  endfunction : scs_high_len

  // Bit clock low phase in core cycles
  function automatic logic [CNT_W-1:0] scs_low_len(input logic [DIV_W-1:0] div);
    logic [CNT_W-1:0] d;
    d = scs_div_eff(div);
    return d[0] ? ((d + 1'b1) >> 1) : (d >> 1);
  endfunction : scs_low_len

endpackage : scs_pkg

//--- hdl/scs_sync.sv
`timescale 1ns/1ps
module scs_sync
  import scs_pkg::*;
#(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);

  logic [W-1:0] meta;

  // Two flops per pin; only the second stage is visible outside
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta     <= RST_VAL;
      pin_sync <= RST_VAL;
    end else begin
      meta     <= pin_in;
      pin_sync <= meta;
    end
  end

endmodule : scs_sync

//--- hdl/scs_clkgen.sv
`timescale 1ns/1ps
module scs_clkgen
  import scs_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             run,
  input  wire logic             start_low,
  input  wire logic [DIV_W-1:0] rate_gen_divider,
  output logic                  fall_tick,
  output logic                  rise_tick
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] hi_len;
  logic [CNT_W-1:0] lo_len;
  logic             sample_rate_clock;

  // Odd divider splits evenly, even divider gives the extra cycle to high
  assign hi_len = scs_high_len(rate_gen_divider);  // [RQ3]
  assign lo_len = scs_low_len(rate_gen_divider);   // [RQ4]

  // Phase counter; reloaded while stopped so each frame starts aligned
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt               <= '0;
      sample_rate_clock <= 1'b1;
    end else if (!run) begin
      sample_rate_clock <= ~start_low;
      cnt               <= start_low ? lo_len - 1'b1 : hi_len - 1'b1;
    end else if (cnt == '0) begin
      sample_rate_clock <= ~sample_rate_clock;
      cnt               <= sample_rate_clock ? lo_len - 1'b1 : hi_len - 1'b1;  // [RQ2]
    end else begin
      cnt <= cnt - 1'b1;
    end
  end

  // Ticks mark the last cycle of each phase
  assign fall_tick = run & (cnt == '0) & sample_rate_clock;
  assign rise_tick = run & (cnt == '0) & ~sample_rate_clock;

endmodule : scs_clkgen

//--- hdl/scs_top.sv
// Function
// RQ1: Slave needs rate generator at half core clock
// RQ2: Master bit period is divider plus one; divider zero runs as one, giving two cycles
// RQ3: High phase half, or divider/2+1 when even
// RQ4: Low phase half, or divider/2 when even
// RQ5: Master drives inverted, active-low select
// RQ6: Slave inverts incoming active-low select pins
// RQ7: Master: tx clock/frame out, rx in
// RQ8: Slave: all clock and frame pins input
// RQ9: Select low before first edge starts transfer
// RQ10: Mode 10b: sample rising, change after falling
// RQ11: Mode 11b: change after rising, sample falling
// RQ12: Mode 10b: lead high-phase, trail full period
// RQ13: Mode 11b: lead full period, trail high-phase
// RQ14: Data pin released after last bit
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module scs_top
  import scs_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              tx_bit_clock_pin_i,
  output logic                   tx_bit_clock_pin_o,
  output logic                   tx_bit_clock_pin_oe,
  input  wire logic              tx_frame_pin_i,
  output logic                   tx_frame_pin_o,
  output logic                   tx_frame_pin_oe,
  input  wire logic              rx_frame_pin_i,
  output logic                   serial_out_pin_o,
  output logic                   serial_out_pin_oe,
  input  wire logic              serial_in_pin_i
);

  scs_ctrl_s         ctrl;
  scs_status_s       status;
  scs_state_e        state;
  logic [DIV_W-1:0]  rate_div;
  logic [DATA_W-1:0] tx_word;
  logic [DATA_W-1:0] rx_word;
  logic [DATA_W-1:0] tx_sh;
  logic [DATA_W-1:0] rx_sh;
  logic [4:0]        bit_cnt;
  logic [4:0]        edge_cnt;
  logic              tx_pending;
  logic              rx_full;
  logic              trail_half;
  logic              aw_hold;
  logic              w_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic [3:0]        pin_s;
  logic              s_clk;
  logic              s_txf;
  logic              s_rxf;
  logic              sdi;
  logic              s_clk_d;
  logic              s_txf_act_d;
  logic              fall_tick;
  logic              rise_tick;

  // Configuration decode
  logic mode_ok;
  logic mode11;
  logic pol_ok;
  logic is_m;
  logic is_s;
  assign mode_ok = (ctrl.clock_stop_mode == MODE_STOP_NODLY) ||
                   (ctrl.clock_stop_mode == MODE_STOP_DLY);
  assign mode11  = (ctrl.clock_stop_mode == MODE_STOP_DLY);
  assign pol_ok  = ctrl.tx_clock_polarity & ctrl.tx_frame_polarity & ctrl.rx_frame_polarity;
  // Master only with clock and frame out, receive side in
  assign is_m = mode_ok & pol_ok & ctrl.rate_gen_source_sel &
                ctrl.tx_clock_direction & ctrl.tx_frame_direction &
                ~ctrl.rx_clock_direction & ~ctrl.rx_frame_direction;  // [RQ7]
  // Slave only with every clock and frame pin in and the generator at half rate
  assign is_s = mode_ok & pol_ok & ctrl.rate_gen_source_sel &
                (rate_div == DIV_W'(1)) &
                ~ctrl.tx_clock_direction & ~ctrl.tx_frame_direction &
                ~ctrl.rx_clock_direction & ~ctrl.rx_frame_direction;  // [RQ1] [RQ8]

  // Pins from the far side pass two flops first
  scs_sync #(.W(4), .RST_VAL(4'hf)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   ({tx_bit_clock_pin_i, tx_frame_pin_i, rx_frame_pin_i, serial_in_pin_i}),
    .pin_sync (pin_s)
  );
  assign {s_clk, s_txf, s_rxf, sdi} = pin_s;

  // Select arrives active low; invert before use
  logic s_txf_act;
  logic s_rxf_act;
  assign s_txf_act = ~s_txf;  // [RQ6]
  assign s_rxf_act = ~s_rxf;  // [RQ6]

  // Slave edge history, taken from the synchronised copies only
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_clk_d     <= 1'b1;
      s_txf_act_d <= 1'b0;
    end else begin
      s_clk_d     <= s_clk;
      s_txf_act_d <= s_txf_act;
    end
  end

  // Bit clock phase timing for master
  scs_clkgen u_clkgen (
    .core_clk         (core_clk),
    .rstn             (rstn),
    .run              (state != ST_IDLE),
    .start_low        (mode11),
    .rate_gen_divider (rate_div),
    .fall_tick        (fall_tick),
    .rise_tick        (rise_tick)
  );

  // Unified events for both roles; slave ignores edges outside select
  logic start_go;
  logic ev_start;
  logic ev_fall;
  logic ev_rise;
  logic last_rise;
  logic shift_ev;
  logic sample_ev;
  logic s_end;
  assign start_go  = is_m & tx_pending & (state == ST_IDLE);
  assign last_rise = (edge_cnt == 5'(DATA_W - 1));
  assign s_end     = is_s & ~s_txf_act & s_txf_act_d;
  assign ev_start  = start_go | (is_s & s_txf_act & ~s_txf_act_d);  // [RQ9]
  assign ev_fall   = is_m ? (((state == ST_LEAD) | (state == ST_SHIFT)) & fall_tick)
                          : (is_s & s_txf_act & s_clk_d & ~s_clk);  // [RQ9]
  assign ev_rise   = is_m ? ((state == ST_SHIFT) & rise_tick)
                          : (is_s & s_txf_act & ~s_clk_d & s_clk);
  // Mode picks which edge launches and which one captures
  assign shift_ev  = mode11 ? (ev_rise & ~(is_m & last_rise)) : ev_fall;  // [RQ10] [RQ11]
  assign sample_ev = (mode11 ? ev_fall : ev_rise) & (is_m | s_rxf_act);  // [RQ10] [RQ11]

  // Master sequencer: lead, shift, trail around each frame
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state      <= ST_IDLE;
      trail_half <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          trail_half <= 1'b0;
          if (start_go) state <= ST_LEAD;
        end
        ST_LEAD: begin
          // 10b starts high, 11b starts low so a full period passes
          if (fall_tick) state <= ST_SHIFT;  // [RQ12] [RQ13]
        end
        ST_SHIFT: begin
          if (rise_tick && last_rise) state <= ST_TRAIL;
        end
        ST_TRAIL: begin
          if (fall_tick) trail_half <= 1'b1;
          if (mode11 ? fall_tick : (rise_tick && trail_half)) begin
            state <= ST_IDLE;  // [RQ12] [RQ13]
          end
        end
      endcase
      if (!is_m) state <= ST_IDLE;
    end
  end

  // Master bit clock, idles high and stops between frames
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_bit_clock_pin_o <= 1'b1;
      edge_cnt           <= '0;
    end else begin
      if (start_go) edge_cnt <= '0;
      if (is_m && ev_fall) tx_bit_clock_pin_o <= 1'b0;  // [RQ2]
      if (is_m && ev_rise) begin
        tx_bit_clock_pin_o <= 1'b1;
        edge_cnt           <= edge_cnt + 5'h01;
      end
      if (!is_m) tx_bit_clock_pin_o <= 1'b1;
    end
  end

  // Pin directions follow the role
  assign tx_bit_clock_pin_oe = is_m;  // [RQ7] [RQ8]
  assign tx_frame_pin_oe     = is_m;  // [RQ7] [RQ8]
  // Internal frame is high-active; polarity bit inverts it onto the pin
  assign tx_frame_pin_o = ctrl.tx_frame_polarity ? (state == ST_IDLE)
                                                 : (state != ST_IDLE);  // [RQ5]

  // Transmit shifter; first bit presented as soon as the frame opens
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_sh            <= DATA_RST;
      serial_out_pin_o <= 1'b0;
    end else if (ev_start) begin
      tx_sh            <= mode11 ? {tx_word[DATA_W-2:0], 1'b0} : tx_word;
      serial_out_pin_o <= tx_word[DATA_W-1];
    end else if (shift_ev) begin
      tx_sh            <= {tx_sh[DATA_W-2:0], 1'b0};
      serial_out_pin_o <= tx_sh[DATA_W-1];  // [RQ10] [RQ11]
    end
  end

  // Data pin enable; the driver lets go once the last bit is done
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      serial_out_pin_oe <= 1'b0;
    end else if (!is_m && !is_s) begin
      serial_out_pin_oe <= 1'b0;
    end else if (ev_start) begin
      serial_out_pin_oe <= 1'b1;
    end else if (is_m && mode11 && ev_rise && last_rise) begin
      serial_out_pin_oe <= 1'b0;  // [RQ14]
    end else if (is_m && !mode11 && state == ST_TRAIL && fall_tick) begin
      serial_out_pin_oe <= 1'b0;  // [RQ14]
    end else if (s_end) begin
      serial_out_pin_oe <= 1'b0;  // [RQ14]
    end
  end

  // Receive shifter; a full word lands in the holding register
  logic rx_done;
  assign rx_done = sample_ev & (bit_cnt == 5'(DATA_W - 1));
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_sh   <= DATA_RST;
      rx_word <= DATA_RST;
      bit_cnt <= '0;
    end else if (ev_start || s_end) begin
      bit_cnt <= '0;
    end else if (sample_ev) begin
      rx_sh   <= {rx_sh[DATA_W-2:0], sdi};
      bit_cnt <= rx_done ? 5'h00 : bit_cnt + 5'h01;
      if (rx_done) rx_word <= {rx_sh[DATA_W-2:0], sdi};
    end
  end

  // Bus handshakes: one write and one read in flight
  logic wr_fire;
  logic rd_fire;
  logic rd_rx;
  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire       = aw_hold & w_hold & ~s_axi_bvalid;
  assign rd_fire       = s_axi_arvalid & s_axi_arready;
  assign rd_rx         = rd_fire & ({s_axi_araddr[ADDR_W-1:2], 2'b00} == OFS_RXDATA);

  // Write address and data are caught in either order
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
      end
    end
  end

  // Byte lanes merged into the old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  // Merged words are cut back to each register's own width on purpose
  logic [31:0] ctrl_m;
  logic [31:0] rate_m;
  logic [31:0] txw_m;
  assign ctrl_m = merge({22'h000000, ctrl}, w_data, w_strb);
  assign rate_m = merge({24'h000000, rate_div}, w_data, w_strb);
  assign txw_m  = merge({16'h0000, tx_word}, w_data, w_strb);

  // Register writes and write response; addresses outside the map answer SLVERR
  logic wr_hit;
  assign wr_hit = (aw_addr == OFS_CTRL) || (aw_addr == OFS_RATE) ||
                  (aw_addr == OFS_TXDATA) || (aw_addr == OFS_RXDATA) ||
                  (aw_addr == OFS_STATUS);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl         <= CTRL_RST;
      rate_div     <= RATE_RST;
      tx_word      <= DATA_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        if (aw_addr == OFS_CTRL) begin
          ctrl <= scs_ctrl_s'(ctrl_m[9:0]);
        end
        if (aw_addr == OFS_RATE) begin
          rate_div <= rate_m[DIV_W-1:0];
        end
        if (aw_addr == OFS_TXDATA) begin
          tx_word <= txw_m[DATA_W-1:0];
        end
      end
    end
  end

  // Sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_pending <= 1'b0;
      rx_full    <= 1'b0;
    end else begin
      tx_pending <= (tx_pending & ~ev_start) | (wr_fire & (aw_addr == OFS_TXDATA));
      rx_full    <= (rx_full & ~rd_rx) | rx_done;
    end
  end

  assign status.busy       = is_m ? (state != ST_IDLE) : (is_s & s_txf_act);
  assign status.rx_full    = rx_full;
  assign status.tx_pending = tx_pending;
  assign status.cfg_err    = mode_ok & ~is_m & ~is_s;

  // Read data is registered with the response
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else begin
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
          OFS_CTRL:   s_axi_rdata <= {22'h000000, ctrl};
          OFS_RATE:   s_axi_rdata <= {24'h000000, rate_div};
          OFS_TXDATA: s_axi_rdata <= {16'h0000, tx_word};
          OFS_RXDATA: s_axi_rdata <= {16'h0000, rx_word};
          OFS_STATUS: s_axi_rdata <= {28'h0000000, status};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Checking helpers: level lengths of the master clock and lead time
  logic             sclk_d;
  logic [CNT_W:0]   gap;
  logic [CNT_W:0]   prev_gap;
  logic [CNT_W+1:0] lead_gap;
  logic [CNT_W:0]   exp_hi;
  logic [CNT_W:0]   exp_lo;
  logic             tx_msb;
  assign exp_hi = (CNT_W+1)'(scs_high_len(rate_div));
  assign exp_lo = (CNT_W+1)'(scs_low_len(rate_div));
  assign tx_msb = tx_sh[DATA_W-1];
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_d   <= 1'b1;
      gap      <= '0;
      prev_gap <= '0;
      lead_gap <= '0;
    end else begin
      sclk_d <= tx_bit_clock_pin_o;
      if (tx_bit_clock_pin_o != sclk_d) begin
        gap      <= (CNT_W+1)'(1);
        prev_gap <= gap;
      end else if (~&gap) begin
        gap <= gap + 1'b1;
      end
      if (state == ST_IDLE) lead_gap <= '0;
      else if (~&lead_gap) lead_gap <= lead_gap + 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_rq1;
    ev_start && !is_m |-> ctrl.rate_gen_source_sel && rate_div == DIV_W'(1);
  endproperty
  a_rq1: assert property (p_rq1) else $error("slave frame without half-rate generator"); // [RQ1]

  property p_rq2;
    is_m && $fell(tx_bit_clock_pin_o) && edge_cnt != '0 |-> gap + prev_gap == exp_hi + exp_lo;
  endproperty
  a_rq2: assert property (p_rq2) else $error("master bit period wrong"); // [RQ2]

  property p_rq3;
    is_m && $fell(tx_bit_clock_pin_o) && edge_cnt != '0 |-> gap == exp_hi;
  endproperty
  a_rq3: assert property (p_rq3) else $error("high phase length wrong"); // [RQ3]

  property p_rq4;
    is_m && $rose(tx_bit_clock_pin_o) && state != ST_IDLE |-> gap == exp_lo;
  endproperty
  a_rq4: assert property (p_rq4) else $error("low phase length wrong"); // [RQ4]

  property p_rq5;
    is_m && state != ST_IDLE |-> !tx_frame_pin_o && tx_frame_pin_oe;
  endproperty
  a_rq5: assert property (p_rq5) else $error("master select not driven low"); // [RQ5]

  property p_rq6;
    is_s && $fell(s_txf) |=> serial_out_pin_oe && status.busy;
  endproperty
  a_rq6: assert property (p_rq6) else $error("slave select not taken"); // [RQ6]

  property p_rq8;
    is_s |-> !tx_bit_clock_pin_oe && !tx_frame_pin_oe;
  endproperty
  a_rq8: assert property (p_rq8) else $error("slave drives a clock or frame pin"); // [RQ8]

  property p_rq10;
    is_m && !mode11 && ev_rise |=> rx_sh[0] == $past(sdi);
  endproperty
  a_rq10: assert property (p_rq10) else $error("10b sample not at rising edge"); // [RQ10]

  property p_rq11;
    is_m && mode11 && ev_rise && !last_rise |=> serial_out_pin_o == $past(tx_msb);
  endproperty
  a_rq11: assert property (p_rq11) else $error("11b data not launched at rising edge"); // [RQ11]

  property p_rq12;
    is_m && $fell(tx_bit_clock_pin_o) && edge_cnt == '0 |->
      lead_gap == (CNT_W+2)'(mode11 ? exp_hi + exp_lo : exp_hi);
  endproperty
  a_rq12: assert property (p_rq12) else $error("select lead before first fall wrong"); // [RQ12] [RQ13]

  property p_rq13;
    is_m && $rose(tx_frame_pin_o) |-> gap == (mode11 ? exp_hi : exp_hi + exp_lo);
  endproperty
  a_rq13: assert property (p_rq13) else $error("select trail after last rise wrong"); // [RQ12] [RQ13]

  property p_rq14;
    is_m && $rose(tx_frame_pin_o) |-> !serial_out_pin_oe ##1 !serial_out_pin_oe;
  endproperty
  a_rq14: assert property (p_rq14) else $error("data pin still driven after frame"); // [RQ14]

  c_m10: cover property (is_m && !mode11 && $rose(tx_frame_pin_o));
  c_m11: cover property (is_m && mode11 && $rose(tx_frame_pin_o));
  c_slv: cover property (is_s && rx_done);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule : scs_top

//--- testbench/scs_peer.sv
`timescale 1ns/1ps
// Far-side slave: one word each way per frame
module scs_peer (
  input  wire logic        sclk,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  input  wire logic        mode11,
  input  wire logic [15:0] tx_word,
  output logic             miso,
  output logic [15:0]      rx_word
);
  logic [15:0] sh;
  int          nf;
  initial sh = 16'hffff;
  assign miso = sh[15];
  // Select low enables us with the first bit already out
  always @(negedge sel_n) begin
    sh = tx_word;
    nf = 0;
  end
  // Deselected, so the line must not keep showing the last bit
  always @(posedge sel_n) sh = ~sh;
  // 10b captures on rise, 11b changes on rise
  always @(posedge sclk) begin
    if (!sel_n && !mode11) rx_word = {rx_word[14:0], mosi};
    if (!sel_n && mode11) sh = {sh[14:0], ~sh[15]};
  end
  // 10b changes after each fall but the first, 11b captures on fall
  always @(negedge sclk) begin
    if (!sel_n && mode11) rx_word = {rx_word[14:0], mosi};
    if (!sel_n && !mode11 && nf++ > 0) sh = {sh[14:0], ~sh[15]};
  end
endmodule : scs_peer

//--- testbench/serial_port_spi_clock_stop_bench.sv
`timescale 1ns/1ps
module serial_port_spi_clock_stop_bench;
  import scs_pkg::*;
  logic              core_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready, tx_bit_clock_pin_i, tx_bit_clock_pin_o, tx_bit_clock_pin_oe;
  logic              tx_frame_pin_i, tx_frame_pin_o, tx_frame_pin_oe, rx_frame_pin_i;
  logic              serial_out_pin_o, serial_out_pin_oe, serial_in_pin_i, mode11, pclk, psel;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, w, d, seed;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rr;
  logic [15:0]       peer_tx, peer_rx, txq[$];
  int                bad_count, cmp_count, cyc, hi_n, lo_n, lead_c, lead_n, trail_c, trail_n;
  int                dv, hi, lo;
  scs_top u_scs_top (.*);
  // Released select and data lines float high through pull-ups
  scs_peer u_scs_peer (.sclk(tx_bit_clock_pin_o), .sel_n(tx_frame_pin_o | ~tx_frame_pin_oe),
    .mosi(serial_out_pin_oe ? serial_out_pin_o : 1'b1), .mode11(mode11), .tx_word(peer_tx),
    .miso(serial_in_pin_i), .rx_word(peer_rx));
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Phase, lead and trail lengths in core cycles, seen one edge late
  always @(posedge core_clk) begin
    pclk <= tx_bit_clock_pin_o;
    psel <= tx_frame_pin_o;
    cyc <= (tx_bit_clock_pin_o != pclk) ? 1 : cyc + 1;
    if (tx_bit_clock_pin_o != pclk && pclk) hi_n <= cyc;
    if (tx_bit_clock_pin_o != pclk && !pclk) lo_n <= cyc;
    lead_c <= tx_frame_pin_o ? 0 : lead_c + 1;
    if (pclk && !tx_bit_clock_pin_o && lead_n == 0) lead_n <= lead_c;
    trail_c <= (tx_bit_clock_pin_o && !pclk) ? 1 : trail_c + 1;
    if (tx_frame_pin_o && !psel) trail_n <= trail_c;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // Each channel released once taken; waits for the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : rd
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rstn, mode11, peer_tx} = 0;
    {tx_bit_clock_pin_i, tx_frame_pin_i, rx_frame_pin_i, pclk, psel} = '1;
    s_axi_wstrb = 4'hf;
    seed = 32'h123c;
    repeat (16) @(posedge core_clk);
    rstn <= 1;
    rd(OFS_RATE);
    chk(d, 32'h1);
    rd(8'h40);
    chk(rr, RESP_SLVERR);
    wr(OFS_CTRL, 32'h1c | MODE_STOP_NODLY);
    chk(rr, RESP_OKAY);
    chk({tx_bit_clock_pin_oe, tx_frame_pin_oe}, 0);
    $display("register checks done");
    // Odd and even divider in both stop modes, random words each way
    for (int i = 0; i < 4; i++) begin
      // Input sync costs two cycles, so each phase must last three or more
      dv = 5 + i % 2;
      hi = (dv % 2) ? (dv + 1) / 2 : dv / 2 + 1;
      lo = (dv % 2) ? (dv + 1) / 2 : dv / 2;
      mode11 <= (i > 1);
      w = xs();
      peer_tx <= w[31:16];
      txq.push_back(w[15:0]);
      lead_n <= 0;
      wr(OFS_RATE, dv);
      wr(OFS_CTRL, (i > 1) ? 32'h27f : 32'h27e);
      chk({tx_bit_clock_pin_oe, tx_frame_pin_oe}, 2'h3);
      wr(OFS_TXDATA, w);
      @(posedge tx_frame_pin_o);
      repeat (2) @(posedge core_clk);
      chk(serial_out_pin_oe, 0);
      chk(peer_rx, txq.pop_front());
      chk(hi_n, hi);
      chk(lo_n, lo);
      chk(lead_n, (i > 1) ? hi + lo : hi);
      chk(trail_n, (i > 1) ? hi : hi + lo);
      rd(OFS_RXDATA);
      chk(d, peer_tx);
      $display("frame %0d done", i);
    end
    // Slave role: half-rate generator, select driven from the far side
    wr(OFS_RATE, 1);
    wr(OFS_CTRL, 32'h21e);
    chk({tx_bit_clock_pin_oe, tx_frame_pin_oe}, 0);
    {tx_frame_pin_i, rx_frame_pin_i} <= 2'h0;
    repeat (5) @(posedge core_clk);
    chk({serial_out_pin_oe, serial_out_pin_o}, {1'b1, w[15]});
    {tx_frame_pin_i, rx_frame_pin_i} <= 2'h3;
    repeat (5) @(posedge core_clk);
    chk(serial_out_pin_oe, 0);
    $display("slave select done");
    report_and_stop();
  end
  // A hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    report_and_stop();
  end
endmodule : serial_port_spi_clock_stop_bench
